// *** rtl/rf_event_timer_consts.svh ***
// register indices, field positions, masks and reset values of the event timer
// assumes a 32-bit register bus with byte addresses equal to four times the index
`ifndef RF_EVENT_TIMER_CONSTS_SVH
`define RF_EVENT_TIMER_CONSTS_SVH

`define EVT_IDX_CONFIG          8'h3F
`define EVT_IDX_RELOAD          8'h40
`define EVT_IDX_STATUS          8'h41
`define EVT_ADDR_W              10

`define EVT_CFG_RESET           32'h0000_0000
`define EVT_RELOAD_RESET        32'h0000_0000
`define EVT_CFG_RW_MASK         32'h7F03_FC7F
`define EVT_RELOAD_RW_MASK      32'h000F_FFFF

`define EVT_BIT_HALT_RX_BEGIN   30
`define EVT_BIT_HALT_TX_BEGIN   29
`define EVT_BIT_HALT_EXT_ON     28
`define EVT_BIT_HALT_EXT_OFF    27
`define EVT_BIT_HALT_INT_ON     26
`define EVT_BIT_HALT_INT_OFF    25
`define EVT_BIT_HALT_RX_ACT     24
`define EVT_BIT_START_RX_BEGIN  17
`define EVT_BIT_START_RX_END    16
`define EVT_BIT_START_TX_BEGIN  15
`define EVT_BIT_START_TX_END    14
`define EVT_BIT_START_EXT_ON    13
`define EVT_BIT_START_EXT_OFF   12
`define EVT_BIT_START_INT_ON    11
`define EVT_BIT_START_INT_OFF   10
`define EVT_BIT_START_NOW       8
`define EVT_BIT_SINGLE_RUN      6
`define EVT_POS_RATE_LSB        3
`define EVT_BIT_CLK_SOURCE      2
`define EVT_BIT_AUTO_RELOAD     1
`define EVT_BIT_ENABLE          0

`define EVT_COUNT_W             20
`define EVT_STAT_BIT_RUNNING    20
`define EVT_STAT_BIT_EXPIRED    21

`define EVT_DIV_W               8
`define EVT_DIV_FULL            8'hFF

`endif

// *** rtl/rf_event_timer_pkg.sv ***
// types shared by the event timer and its tick divider
// assumes nothing beyond a SystemVerilog compiler
package rf_event_timer_pkg;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_RUN     = 3'b010,
        ST_EXPIRED = 3'b100
    } timer_state_t;

    typedef logic [19:0] count_t;

endpackage

// *** rtl/rf_event_timer_prescaler.sv ***
// tick divider: turns the rf clock tick into the prescaled tick
// assumes rf_tick_in is a one-cycle strobe per rf clock period, same clock domain
`timescale 1ns/100ps
`include "rf_event_timer_consts.svh"

module rf_event_timer_prescaler
    import rf_event_timer_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk_in,
    input  wire logic       resetn_in,
    input  wire logic       clk_en_in,
    // rate control
    input  wire logic       rf_tick_in,
    input  wire logic [2:0] tick_rate_select_in,
    // prescaled tick
    output logic            tick_out
);

    logic [`EVT_DIV_W-1:0] div_cnt_r;
    logic [`EVT_DIV_W-1:0] div_cnt_nxt;
    logic                  tick_r;
    logic                  tick_nxt;
    logic [`EVT_DIV_W-1:0] div_mask;

    // code n divides the rf tick by two to the power n+1
    always_comb begin
        div_mask    = `EVT_DIV_FULL >> (3'd7 - tick_rate_select_in);
        div_cnt_nxt = div_cnt_r;
        tick_nxt    = 1'b0;
        if (rf_tick_in) begin
            div_cnt_nxt = div_cnt_r + 8'h01;
            tick_nxt    = ((div_cnt_r & div_mask) == div_mask);
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            div_cnt_r <= 8'h00;
            tick_r    <= 1'b0;
        end else if (clk_en_in) begin
            div_cnt_r <= div_cnt_nxt;
            tick_r    <= tick_nxt;
        end
    end

    assign tick_out = tick_r;

endmodule

// *** rtl/rf_event_timer.sv ***
// event timer of the contactless front end: register slave, start/halt logic, down-counter
// assumes event strobes and field levels come from logic on sys_clk_in (no synchronisers)
// assumes rf_tick_in pulses once per rf interface clock period
`timescale 1ns/100ps
`include "rf_event_timer_consts.svh"

//
// Contract
// - start on first received bit if enabled
// - start when reception completes if enabled
// - start on transmit begin or end bits
// - start on external field on/off bits
// - start on internal field on/off bits
// - immediate-start bit starts timer at once
// - single run: no reload before reaching zero
// - rate code halves tick from 6.78 MHz
// - source bit picks rf clock or prescaled tick
// - reload off: stop at expiry, hold zero
// - reload on: reload preset on each expiry
// - timer inactive unless enable bit set
// - 20-bit preset, reset zero, loaded on start
// - separate halt enables per interface event; none for rx end or tx end
module rf_event_timer
    import rf_event_timer_pkg::*;
(
    // clock, reset, clock enable
    input  wire logic                    sys_clk_in,
    input  wire logic                    resetn_in,
    input  wire logic                    clk_en_in,
    // avalon-mm register slave
    input  wire logic [`EVT_ADDR_W-1:0]  avs_address_in,
    input  wire logic                    avs_read_in,
    input  wire logic                    avs_write_in,
    input  wire logic [31:0]             avs_writedata_in,
    input  wire logic [3:0]              avs_byteenable_in,
    output logic [31:0]                  avs_readdata_out,
    output logic                         avs_waitrequest_out,
    // rf interface events
    input  wire logic                    rf_tick_in,
    input  wire logic                    rx_begin_in,
    input  wire logic                    rx_end_in,
    input  wire logic                    tx_begin_in,
    input  wire logic                    tx_end_in,
    input  wire logic                    rx_activity_in,
    input  wire logic                    ext_field_in,
    input  wire logic                    int_field_in,
    // timer state
    output logic                         timer_running_out,
    output logic                         timer_expired_out,
    output logic [`EVT_COUNT_W-1:0]      timer_count_out
);

    // register slave state
    logic [31:0]      cfg_r;
    logic [31:0]      cfg_nxt;
    logic [31:0]      reload_r;
    logic [31:0]      reload_nxt;
    logic [31:0]      rdata_r;
    logic [31:0]      rdata_nxt;
    logic             wait_r;
    logic             wait_nxt;
    logic             start_now_r;
    logic             start_now_nxt;
    logic [31:0]      be_mask;
    logic             req;
    logic             wr_commit;
    logic [7:0]       word_idx;
    logic             addr_aligned;

    // timer state
    timer_state_t     state_r;
    timer_state_t     state_nxt;
    count_t           count_r;
    count_t           count_nxt;
    logic             expired_pulse_r;
    logic             expired_pulse_nxt;
    logic             ext_prev_r;
    logic             int_prev_r;

    // event decode
    logic             prescaled_tick;
    logic             tick;
    logic             start_evt;
    logic             halt_evt;
    logic             ext_on;
    logic             ext_off;
    logic             int_on;
    logic             int_off;
    count_t           preset;

    assign req          = avs_read_in | avs_write_in;
    assign wr_commit    = avs_write_in & ~wait_r;
    assign word_idx     = avs_address_in[9:2];
    assign addr_aligned = (avs_address_in[1:0] == 2'b00);
    assign preset       = reload_r[`EVT_COUNT_W-1:0];

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign be_mask[gi*8 +: 8] = {8{avs_byteenable_in[gi]}};
        end
    endgenerate

    rf_event_timer_prescaler u_prescaler (
        .sys_clk_in          (sys_clk_in),
        .resetn_in           (resetn_in),
        .clk_en_in           (clk_en_in),
        .rf_tick_in          (rf_tick_in),
        .tick_rate_select_in (cfg_r[`EVT_POS_RATE_LSB +: 3]),
        .tick_out            (prescaled_tick)
    );

    // bus slave: one wait cycle, read data captured as waitrequest drops
    always_comb begin
        cfg_nxt       = cfg_r;
        reload_nxt    = reload_r;
        rdata_nxt     = rdata_r;
        start_now_nxt = 1'b0;
        wait_nxt      = 1'b1;
        if (req && wait_r) begin
            wait_nxt  = 1'b0;
            rdata_nxt = 32'h0000_0000;
            if (avs_read_in && addr_aligned) begin
                unique case (word_idx)
                    `EVT_IDX_CONFIG: rdata_nxt = cfg_r;
                    `EVT_IDX_RELOAD: rdata_nxt = reload_r;
                    `EVT_IDX_STATUS: begin
                        rdata_nxt[`EVT_COUNT_W-1:0]     = count_r;
                        rdata_nxt[`EVT_STAT_BIT_RUNNING] = (state_r == ST_RUN);
                        rdata_nxt[`EVT_STAT_BIT_EXPIRED] = (state_r == ST_EXPIRED);
                    end
                    default: rdata_nxt = 32'h0000_0000;
                endcase
            end
        end
        if (wr_commit && addr_aligned) begin
            if (word_idx == `EVT_IDX_CONFIG) begin
                cfg_nxt = ((cfg_r & ~be_mask) | (avs_writedata_in & be_mask))
                          & `EVT_CFG_RW_MASK;
                // immediate start acts as a command and is not stored
                start_now_nxt = avs_byteenable_in[1]
                                & avs_writedata_in[`EVT_BIT_START_NOW];
            end
            if (word_idx == `EVT_IDX_RELOAD) begin
                reload_nxt = ((reload_r & ~be_mask) | (avs_writedata_in & be_mask))
                             & `EVT_RELOAD_RW_MASK;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg_r       <= `EVT_CFG_RESET;
            reload_r    <= `EVT_RELOAD_RESET;
            rdata_r     <= 32'h0000_0000;
            wait_r      <= 1'b1;
            start_now_r <= 1'b0;
        end else if (clk_en_in) begin
            cfg_r       <= cfg_nxt;
            reload_r    <= reload_nxt;
            rdata_r     <= rdata_nxt;
            wait_r      <= wait_nxt;
            start_now_r <= start_now_nxt;
        end
    end

    // field edges and event qualification
    always_comb begin
        ext_on  = ext_field_in & ~ext_prev_r;
        ext_off = ~ext_field_in & ext_prev_r;
        int_on  = int_field_in & ~int_prev_r;
        int_off = ~int_field_in & int_prev_r;
        start_evt = (cfg_r[`EVT_BIT_START_RX_BEGIN] & rx_begin_in)
                  | (cfg_r[`EVT_BIT_START_RX_END]   & rx_end_in)
                  | (cfg_r[`EVT_BIT_START_TX_BEGIN] & tx_begin_in)
                  | (cfg_r[`EVT_BIT_START_TX_END]   & tx_end_in)
                  | (cfg_r[`EVT_BIT_START_EXT_ON]   & ext_on)
                  | (cfg_r[`EVT_BIT_START_EXT_OFF]  & ext_off)
                  | (cfg_r[`EVT_BIT_START_INT_ON]   & int_on)
                  | (cfg_r[`EVT_BIT_START_INT_OFF]  & int_off)
                  | start_now_r;
        halt_evt  = (cfg_r[`EVT_BIT_HALT_RX_BEGIN] & rx_begin_in)
                  | (cfg_r[`EVT_BIT_HALT_TX_BEGIN] & tx_begin_in)
                  | (cfg_r[`EVT_BIT_HALT_EXT_ON]   & ext_on)
                  | (cfg_r[`EVT_BIT_HALT_EXT_OFF]  & ext_off)
                  | (cfg_r[`EVT_BIT_HALT_INT_ON]   & int_on)
                  | (cfg_r[`EVT_BIT_HALT_INT_OFF]  & int_off)
                  | (cfg_r[`EVT_BIT_HALT_RX_ACT]   & rx_activity_in);
        tick = cfg_r[`EVT_BIT_CLK_SOURCE] ? prescaled_tick : rf_tick_in;
    end

    // down-counter; a halt in the same cycle as a start wins
    always_comb begin
        state_nxt         = state_r;
        count_nxt         = count_r;
        expired_pulse_nxt = 1'b0;
        if (!cfg_r[`EVT_BIT_ENABLE]) begin
            state_nxt = ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE, ST_EXPIRED: begin
                    if (start_evt && !halt_evt) begin
                        state_nxt = ST_RUN;
                        count_nxt = preset;
                    end
                end
                ST_RUN: begin
                    if (halt_evt) begin
                        state_nxt = ST_IDLE;
                    end else if (count_r == 20'h0_0000) begin
                        expired_pulse_nxt = 1'b1;
                        if (cfg_r[`EVT_BIT_AUTO_RELOAD]) begin
                            count_nxt = preset;
                        end else begin
                            state_nxt = ST_EXPIRED;
                        end
                    end else if (start_evt && !cfg_r[`EVT_BIT_SINGLE_RUN]) begin
                        // single run ignores restarts until zero is reached
                        count_nxt = preset;
                    end else if (tick) begin
                        count_nxt = count_r - 20'h0_0001;
                    end
                end
                default: state_nxt = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_r         <= ST_IDLE;
            count_r         <= 20'h0_0000;
            expired_pulse_r <= 1'b0;
            ext_prev_r      <= 1'b0;
            int_prev_r      <= 1'b0;
        end else if (clk_en_in) begin
            state_r         <= state_nxt;
            count_r         <= count_nxt;
            expired_pulse_r <= expired_pulse_nxt;
            ext_prev_r      <= ext_field_in;
            int_prev_r      <= int_field_in;
        end
    end

    assign avs_readdata_out    = rdata_r;
    assign avs_waitrequest_out = wait_r;
    // one-hot run bit taken straight from the state flop
    assign timer_running_out   = state_r[1];
    assign timer_expired_out   = expired_pulse_r;
    assign timer_count_out     = count_r;

endmodule

// *** verification/rf_event_timer_assertions.sv ***
// checker: bus handshake and counter behaviour of the event timer
// assumes it is bound onto rf_event_timer, all logic on sys_clk_in
`timescale 1ns/100ps
`include "rf_event_timer_consts.svh"
module rf_event_timer_checker (
    // clock and reset
    input wire logic                    sys_clk_in,
    input wire logic                    resetn_in,
    input wire logic                    clk_en_in,
    // register bus
    input wire logic [`EVT_ADDR_W-1:0]  avs_address_in,
    input wire logic                    avs_read_in,
    input wire logic                    avs_write_in,
    input wire logic [31:0]             avs_readdata_out,
    input wire logic                    avs_waitrequest_out,
    // timer
    input wire logic                    rf_tick_in,
    input wire logic                    timer_running_out,
    input wire logic                    timer_expired_out,
    input wire logic [`EVT_COUNT_W-1:0] timer_count_out
);
    default clocking @(posedge sys_clk_in);
    endclocking
    default disable iff (!resetn_in);
    sequence seq_req_taken;
        clk_en_in && (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    sequence seq_read_done;
        avs_read_in && !avs_waitrequest_out;
    endsequence
    sequence seq_zero_run;
        timer_running_out && timer_count_out == '0;
    endsequence
    sequence seq_step_down;
        timer_running_out && $past(timer_running_out) && timer_count_out < $past(timer_count_out);
    endsequence
    a_wait_one: assert property (seq_req_taken |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
        else $error("waitrequest not low for exactly one cycle");
    a_wait_cause: assert property ($fell(avs_waitrequest_out) |-> $past(avs_read_in || avs_write_in))
        else $error("waitrequest dropped without a request");
    a_unmapped_zero: assert property (seq_read_done and (avs_address_in != 10'h0fc) and
        (avs_address_in != 10'h100) and (avs_address_in != 10'h104) |-> avs_readdata_out == '0)
        else $error("unmapped read not zero");
    a_cfg_reserved: assert property (seq_read_done and (avs_address_in == 10'h0fc) |->
        (avs_readdata_out & ~`EVT_CFG_RW_MASK) == '0) else $error("config reserved bits set");
    a_reload_width: assert property (seq_read_done and (avs_address_in == 10'h100) |->
        avs_readdata_out[31:20] == '0) else $error("reload upper bits set");
    a_expiry_pulse: assert property (seq_zero_run |=> timer_expired_out)
        else $error("no expiry pulse after zero count");
    a_expired_cause: assert property (timer_expired_out |->
        $past(timer_running_out) && $past(timer_count_out) == '0) else $error("stray expiry");
    a_idle_hold: assert property (!timer_running_out ##1 !timer_running_out |->
        $stable(timer_count_out)) else $error("count moved while idle");
    a_step_one: assert property (seq_step_down |->
        timer_count_out == $past(timer_count_out) - 1) else $error("count dropped by more than one");
    a_tick_cause: assert property (seq_step_down |->
        $past(rf_tick_in) || $past(rf_tick_in, 2)) else $error("count dropped without tick");
endmodule

bind rf_event_timer rf_event_timer_checker chk (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .clk_en_in(clk_en_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .rf_tick_in(rf_tick_in), .timer_running_out(timer_running_out),
    .timer_expired_out(timer_expired_out), .timer_count_out(timer_count_out)
);

// *** verification/rf_event_timer_tb.sv ***
// self-checking bench: register access, start and halt events, counting modes
// assumes the design and the checker are compiled first
`timescale 1ns/100ps
`include "rf_event_timer_consts.svh"
module rf_event_timer_tb;
    import rf_event_timer_pkg::*;
    localparam int          LIMIT = 20000;
    logic                   sys_clk_in, resetn_in, rf_tick_in, avs_read_in, avs_write_in;
    logic [`EVT_ADDR_W-1:0] avs_address_in;
    logic [31:0]            avs_writedata_in, avs_readdata_out, q, r;
    logic                   avs_waitrequest_out, timer_running_out, timer_expired_out;
    logic [4:0]             ev;
    logic [1:0]             fld;
    count_t                 timer_count_out, p;
    int                     err_total = 0, cmp_count = 0, cyc = 0, seed;
    int                     halt_bit[7] = '{30, 29, 28, 27, 26, 25, 24};
    int                     halt_src[7] = '{0, 2, 4, 5, 6, 7, 8};

    rf_event_timer uut (
        .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .clk_en_in(1'b1),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(4'hf), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .rf_tick_in(rf_tick_in),
        .rx_begin_in(ev[0]), .rx_end_in(ev[1]), .tx_begin_in(ev[2]), .tx_end_in(ev[3]),
        .rx_activity_in(ev[4]), .ext_field_in(fld[0]), .int_field_in(fld[1]),
        .timer_running_out(timer_running_out), .timer_expired_out(timer_expired_out),
        .timer_count_out(timer_count_out)
    );

    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask

    // request held until the edge that sees waitrequest low
    task automatic bus(input logic wr, input int idx, input logic [31:0] d);
        @(posedge sys_clk_in);
        avs_address_in   <= 10'(idx * 4);
        avs_writedata_in <= d;
        avs_write_in     <= wr;
        avs_read_in      <= !wr;
        do @(posedge sys_clk_in);
        while (avs_waitrequest_out !== 1'b0);
        q = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in  <= 1'b0;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge sys_clk_in);
            rf_tick_in <= 1'b1;
        end
        @(posedge sys_clk_in);
        rf_tick_in <= 1'b0;
        #1;
    endtask

    // codes 0..3 and 8 pulse an event, 4..7 drive a field edge after the opposite level
    task automatic fire(input int k);
        @(posedge sys_clk_in);
        if (k >= 4 && k < 8)
            fld[(k - 4) / 2] <= k[0];
        else
            ev[k == 8 ? 4 : k] <= 1'b1;
        @(posedge sys_clk_in);
        if (k >= 4 && k < 8)
            fld[(k - 4) / 2] <= !k[0];
        else
            ev <= '0;
        step(1);
    endtask

    initial begin
        sys_clk_in = 1'b0;
        forever #50 sys_clk_in = ~sys_clk_in;
    end

    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_total++;
            complete_run;
        end
    end

    initial begin
        seed = 32'h0000_a6b4;
        {resetn_in, rf_tick_in, avs_read_in, avs_write_in, ev, fld} = '0;
        avs_address_in = '0;
        avs_writedata_in = '0;
        repeat (8) @(posedge sys_clk_in);
        resetn_in <= 1'b1;
        bus(0, `EVT_IDX_CONFIG, 0);
        check(q, `EVT_CFG_RESET);
        bus(0, `EVT_IDX_RELOAD, 0);
        check(q, `EVT_RELOAD_RESET);
        r = $random(seed);
        bus(1, `EVT_IDX_RELOAD, r);
        bus(1, 8'h04, 32'hffff_ffff);
        bus(0, 8'h04, 0);
        check(q, 32'h0000_0000);
        bus(0, `EVT_IDX_RELOAD, 0);
        check(q, r & `EVT_RELOAD_RW_MASK);
        bus(1, `EVT_IDX_CONFIG, 32'hffff_ffff);
        bus(0, `EVT_IDX_CONFIG, 0);
        check(q, `EVT_CFG_RW_MASK);
        for (int k = 0; k < 8; k++) begin
            p = count_t'($unsigned($random(seed)) % 1000 + 1);
            bus(1, `EVT_IDX_RELOAD, 32'(p));
            bus(1, `EVT_IDX_CONFIG, 32'h1 << (17 - k));
            fire(k);
            check(timer_running_out, 1'b0);
            bus(1, `EVT_IDX_CONFIG, (32'h1 << (17 - k)) | 32'h1);
            fire(k);
            check(timer_running_out, 1'b1);
            check(timer_count_out, p);
            bus(1, `EVT_IDX_CONFIG, 0);
        end
        p = count_t'($unsigned($random(seed)) % 6 + 3);
        bus(1, `EVT_IDX_RELOAD, 32'(p));
        bus(1, `EVT_IDX_CONFIG, 32'h0000_0101);
        step(1);
        check(timer_count_out, p);
        tick(p - 1);
        check(timer_count_out, 32'h0000_0001);
        tick(1);
        step(1);
        check(timer_running_out, 1'b0);
        check(timer_expired_out, 1'b1);
        tick(2);
        check(timer_count_out, 32'h0000_0000);
        bus(1, `EVT_IDX_CONFIG, 32'h0000_0103);
        step(1);
        tick(p);
        step(1);
        check(timer_count_out, p);
        check(timer_running_out, 1'b1);
        bus(1, `EVT_IDX_CONFIG, 32'h0000_0141);
        step(1);
        tick(2);
        bus(1, `EVT_IDX_CONFIG, 32'h0000_0141);
        step(1);
        check(timer_count_out, p - 2);
        bus(1, `EVT_IDX_CONFIG, 32'h0000_0101);
        step(1);
        check(timer_count_out, p);
        for (int i = 0; i < 7; i++) begin
            bus(1, `EVT_IDX_CONFIG, (32'h1 << halt_bit[i]) | 32'h0000_0101);
            step(1);
            tick(1);
            fire(halt_src[i]);
            check(timer_running_out, 1'b0);
            check(timer_count_out, p - 1);
        end
        p = 20'h0_0014;
        bus(1, `EVT_IDX_RELOAD, 32'(p));
        // 3*divisor ticks give exactly three prescaled ticks whatever the divider phase
        for (int c = 0; c < 8; c++) begin
            bus(1, `EVT_IDX_CONFIG, 32'h0000_0105 | (c << 3));
            step(1);
            tick(3 << (c + 1));
            step(2);
            check(timer_count_out, p - 3);
        end
        complete_run;
    end
endmodule
